// *** mul_div_pkg.sv ***
package mul_div_pkg;

   // nibble offsets of the unit's i/o memory window (low address bits)
   localparam logic [2:0] OFS_SRC_LO    = 3'h0;
   localparam logic [2:0] OFS_SRC_HI    = 3'h1;
   localparam logic [2:0] OFS_DST_LO_LO = 3'h2;
   localparam logic [2:0] OFS_DST_LO_HI = 3'h3;
   localparam logic [2:0] OFS_DST_HI_LO = 3'h4;
   localparam logic [2:0] OFS_DST_HI_HI = 3'h5;
   localparam logic [2:0] OFS_CTRL      = 3'h6;

   // bit positions in the control nibble
   localparam int BIT_START    = 0;
   localparam int BIT_ZERO     = 1;
   localparam int BIT_OVERFLOW = 2;
   localparam int BIT_NEGATIVE = 3;

   localparam logic OP_MUL = 1'b0;
   localparam logic OP_DIV = 1'b1;

   // operation latency: the result lands this many clocks after the start write
   localparam int          OP_CYCLES = 10;
   localparam logic [3:0]  OP_LAST   = 4'(OP_CYCLES - 1);
   localparam logic [3:0]  CNT_RST   = 4'h0;
   localparam logic        FLAG_RST  = 1'b0;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN  = 1'b1
   } unit_state_e;

endpackage

// *** mul_div_if.sv ***
`timescale 1ns/100ps
`default_nettype none
// operand snapshot handed from the register side to the arithmetic core, and the core's done, results and overflow handed back
interface mul_div_if;
   logic       start;
   logic       mode;
   logic [7:0] src;
   logic [7:0] dst_lo;
   logic [7:0] dst_hi;
   logic       done;
   logic [7:0] res_lo;
   logic [7:0] res_hi;
   logic       ovf;

   modport ctrl (output start, output mode, output src, output dst_lo, output dst_hi,
                 input done, input res_lo, input res_hi, input ovf);
   modport core (input start, input mode, input src, input dst_lo, input dst_hi,
                 output done, output res_lo, output res_hi, output ovf);
endinterface
`default_nettype wire

// *** mul_div_core.sv ***
`timescale 1ns/100ps
`default_nettype none
module mul_div_core (
   input  wire logic  clk_sys,
   input  wire logic  rst,
   mul_div_if.core    bus
);

   mul_div_pkg::unit_state_e state_ff;
   logic [3:0]  cnt_ff;
   logic        mode_ff;
   logic [7:0]  src_ff;
   logic [15:0] dividend_ff;
   logic        done_ff;
   logic [7:0]  res_lo_ff;
   logic [7:0]  res_hi_ff;
   logic        ovf_ff;

   logic [15:0] product;
   logic [15:0] quotient;
   logic [15:0] remainder;

   // operands captured once; later register writes do not reach here
   always_ff @(posedge clk_sys) begin
      if (bus.start) begin
         mode_ff     <= bus.mode;
         src_ff      <= bus.src;
         dividend_ff <= {bus.dst_hi, bus.dst_lo};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_ff <= mul_div_pkg::ST_IDLE;
         cnt_ff   <= mul_div_pkg::CNT_RST;
      end else if (bus.start) begin
         state_ff <= mul_div_pkg::ST_RUN;
         cnt_ff   <= 4'h1;
      end else begin
         case (state_ff)
            mul_div_pkg::ST_IDLE: begin
               cnt_ff <= mul_div_pkg::CNT_RST;
            end
            mul_div_pkg::ST_RUN: begin
               if (cnt_ff == mul_div_pkg::OP_LAST) begin
                  state_ff <= mul_div_pkg::ST_IDLE;
                  cnt_ff   <= mul_div_pkg::CNT_RST;
               end else begin
                  cnt_ff <= cnt_ff + 4'h1;
               end
            end
            default: begin
               state_ff <= mul_div_pkg::ST_IDLE;
               cnt_ff   <= mul_div_pkg::CNT_RST;
            end
         endcase
      end
   end

   // high operand byte plays no part in a product
   assign product   = {8'h00, dividend_ff[7:0]} * {8'h00, src_ff};
   // zero divisor yields all ones, hence overflow; software must screen it
   assign quotient  = (src_ff == 8'h00) ? 16'hFFFF : dividend_ff / {8'h00, src_ff};
   assign remainder = (src_ff == 8'h00) ? dividend_ff : dividend_ff % {8'h00, src_ff};

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         done_ff   <= 1'b0;
         res_lo_ff <= 8'h00;
         res_hi_ff <= 8'h00;
         ovf_ff    <= 1'b0;
      end else begin
         done_ff <= (state_ff == mul_div_pkg::ST_RUN) && !bus.start
                    && (cnt_ff == mul_div_pkg::OP_LAST);
         if (mode_ff == mul_div_pkg::OP_MUL) begin
            res_lo_ff <= product[7:0];
            res_hi_ff <= product[15:8];
            ovf_ff    <= 1'b0;
         end else begin
            res_lo_ff <= quotient[7:0];
            res_hi_ff <= remainder[7:0];
            ovf_ff    <= (quotient[15:8] != 8'h00);
         end
      end
   end

   assign bus.done   = done_ff;
   assign bus.res_lo = res_lo_ff;
   assign bus.res_hi = res_hi_ff;
   assign bus.ovf    = ovf_ff;

endmodule // mul_div_core
`default_nettype wire

// *** int_mul_div_unit.sv ***
`timescale 1ns/100ps
`default_nettype none
module int_mul_div_unit (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       wr_en,
   input  wire logic [2:0] wr_addr,
   input  wire logic [3:0] wr_data,
   output var  logic [7:0] source_operand_reg,
   output var  logic [7:0] dest_low_byte,
   output var  logic [7:0] dest_high_byte,
   output var  logic       op_select_start,
   output var  logic       negative_flag,
   output var  logic       overflow_flag,
   output var  logic       zero_flag
);

   mul_div_if lnk ();

   logic [7:0] src_ff;
   logic [7:0] dlo_ff;
   logic [7:0] dhi_ff;
   logic       busy_ff;
   logic       neg_ff;
   logic       ovf_ff;
   logic       zero_ff;
   logic       start;
   logic       mode_ff;

   function automatic logic hit(input logic [2:0] ofs);
      hit = wr_en && (wr_addr == ofs);
   endfunction

   assign start = hit(mul_div_pkg::OFS_CTRL);

   // snapshot of operands handed to the core on the start write
   assign lnk.start  = start;
   assign lnk.mode   = wr_data[mul_div_pkg::BIT_START];
   assign lnk.src    = src_ff;
   assign lnk.dst_lo = dlo_ff;
   assign lnk.dst_hi = dhi_ff;

   mul_div_core u_core (
      .clk_sys (clk_sys),
      .rst     (rst),
      .bus     (lnk)
   );

   // no reset: the source operand is undefined until software writes it
   always_ff @(posedge clk_sys) begin
      if (hit(mul_div_pkg::OFS_SRC_LO)) begin
         src_ff[3:0] <= wr_data;
      end
      if (hit(mul_div_pkg::OFS_SRC_HI)) begin
         src_ff[7:4] <= wr_data;
      end
   end

   // local copy of the mode, taken on the same write the core captures it on
   always_ff @(posedge clk_sys) begin
      if (start) begin
         mode_ff <= lnk.mode;
      end
   end

   // result write wins over a nibble write landing in the same cycle
   always_ff @(posedge clk_sys) begin
      if (lnk.done && !lnk.ovf) begin
         dlo_ff <= lnk.res_lo;
         dhi_ff <= lnk.res_hi;
      end else if (lnk.done) begin
         dlo_ff <= dlo_ff;
         dhi_ff <= dhi_ff;
      end else begin
         if (hit(mul_div_pkg::OFS_DST_LO_LO)) begin
            dlo_ff[3:0] <= wr_data;
         end
         if (hit(mul_div_pkg::OFS_DST_LO_HI)) begin
            dlo_ff[7:4] <= wr_data;
         end
         if (hit(mul_div_pkg::OFS_DST_HI_LO)) begin
            dhi_ff[3:0] <= wr_data;
         end
         if (hit(mul_div_pkg::OFS_DST_HI_HI)) begin
            dhi_ff[7:4] <= wr_data;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         busy_ff <= 1'b0;
      end else if (start) begin
         busy_ff <= 1'b1;
      end else if (lnk.done) begin
         busy_ff <= 1'b0;
      end
   end

   // flags follow what the destination bytes hold after the result cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         neg_ff  <= mul_div_pkg::FLAG_RST;
         ovf_ff  <= mul_div_pkg::FLAG_RST;
         zero_ff <= mul_div_pkg::FLAG_RST;
      end else if (lnk.done) begin
         ovf_ff <= lnk.ovf;
         if (mode_ff == mul_div_pkg::OP_MUL) begin
            neg_ff  <= lnk.res_hi[7];
            zero_ff <= ({lnk.res_hi, lnk.res_lo} == 16'h0000);
         end else if (lnk.ovf) begin
            neg_ff  <= dlo_ff[7];
            zero_ff <= (dlo_ff == 8'h00);
         end else begin
            neg_ff  <= lnk.res_lo[7];
            zero_ff <= (lnk.res_lo == 8'h00);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      source_operand_reg <= src_ff;
      // no bypass: bytes and flags reach the pins on the same edge
      dest_low_byte      <= dlo_ff;
      dest_high_byte     <= dhi_ff;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         op_select_start <= 1'b0;
         negative_flag   <= 1'b0;
         overflow_flag   <= 1'b0;
         zero_flag       <= 1'b0;
      end else begin
         op_select_start <= busy_ff;
         negative_flag   <= neg_ff;
         overflow_flag   <= ovf_ff;
         zero_flag       <= zero_ff;
      end
   end

endmodule // int_mul_div_unit
`default_nettype wire

// *** int_mul_div_unit_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module int_mul_div_unit_monitor (
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic       wr_en,
   input wire logic [2:0] wr_addr,
   input wire logic [3:0] wr_data,
   input wire logic [7:0] source_operand_reg,
   input wire logic [7:0] dest_low_byte,
   input wire logic [7:0] dest_high_byte,
   input wire logic       op_select_start,
   input wire logic       negative_flag,
   input wire logic       overflow_flag,
   input wire logic       zero_flag
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic       md_ff;
   logic       bq_ff;
   logic [7:0] sr_ff;
   logic [7:0] hi_ff;
   logic [7:0] lo_ff;
   wire        go = wr_en && wr_addr == mul_div_pkg::OFS_CTRL;
   wire        em = bq_ff && !op_select_start && !md_ff;
   wire        ed = bq_ff && !op_select_start && md_ff;
   always_ff @(posedge clk_sys) begin
      bq_ff <= rst ? 1'b0 : op_select_start;
      if (go) begin
         md_ff <= wr_data[0];
         sr_ff <= source_operand_reg;
         hi_ff <= dest_high_byte;
         lo_ff <= dest_low_byte;
      end
   end
   property p_run; go |-> ##2 op_select_start [*8]; endproperty
   a_run: assert property (p_run) else $error("busy not held");
   property p_lat; go |-> ##11 op_select_start ##1 !op_select_start; endproperty
   a_lat: assert property (p_lat) else $error("bad latency");
   property p_mn; em |-> negative_flag == dest_high_byte[7]; endproperty
   a_mn: assert property (p_mn) else $error("mul sign");
   property p_mv; em |-> !overflow_flag; endproperty
   a_mv: assert property (p_mv) else $error("mul overflow");
   property p_mz; em |-> zero_flag == ({dest_high_byte, dest_low_byte} == 16'h0000); endproperty
   a_mz: assert property (p_mz) else $error("mul zero");
   property p_dv; ed |-> overflow_flag == (hi_ff >= sr_ff); endproperty
   a_dv: assert property (p_dv) else $error("div overflow");
   property p_dk; ed && overflow_flag |-> {dest_high_byte, dest_low_byte} == {hi_ff, lo_ff}; endproperty
   a_dk: assert property (p_dk) else $error("dividend lost");
   property p_dz; ed |-> zero_flag == (dest_low_byte == 8'h00); endproperty
   a_dz: assert property (p_dz) else $error("div zero");
   property p_dn; ed |-> negative_flag == dest_low_byte[7]; endproperty
   a_dn: assert property (p_dn) else $error("div sign");
   c_mul: cover property (em);
   c_div: cover property (ed && !overflow_flag);
   c_ovf: cover property (ed && overflow_flag);
endmodule // int_mul_div_unit_monitor
bind int_mul_div_unit int_mul_div_unit_monitor mon_i (.clk_sys(clk_sys), .rst(rst),
   .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .source_operand_reg(source_operand_reg),
   .dest_low_byte(dest_low_byte), .dest_high_byte(dest_high_byte),
   .op_select_start(op_select_start), .negative_flag(negative_flag),
   .overflow_flag(overflow_flag), .zero_flag(zero_flag));
`default_nettype wire

// *** host_cpu.sv ***
`timescale 1ns/100ps
`default_nettype none
module host_cpu (
   input  wire logic       clk_sys,
   output var  logic       wr_en,
   output var  logic [2:0] wr_addr,
   output var  logic [3:0] wr_data
);
   initial begin
      wr_en = 1'b0;
      wr_addr = 3'h7;
      wr_data = 4'h0;
   end
   // idle bus shows inverted values so stale data never looks valid
   task automatic wr(input logic [2:0] a, input logic [3:0] d);
      @(negedge clk_sys);
      wr_en = 1'b1;
      wr_addr = a;
      wr_data = d;
      @(negedge clk_sys);
      wr_en = 1'b0;
      wr_addr = ~a;
      wr_data = ~d;
   endtask
   task automatic ldb(input logic [2:0] a, input logic [7:0] b);
      wr(a, b[3:0]);
      wr(a + 3'h1, b[7:4]);
   endtask
   task automatic run(input logic m, input logic [7:0] s, input logic [7:0] h, input logic [7:0] l);
      ldb(mul_div_pkg::OFS_SRC_LO, s);
      ldb(mul_div_pkg::OFS_DST_LO_LO, l);
      ldb(mul_div_pkg::OFS_DST_HI_LO, h);
      wr(mul_div_pkg::OFS_CTRL, {3'h0, m});
   endtask
endmodule // host_cpu
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
   typedef struct packed {logic m; logic [7:0] s; logic [15:0] d; logic [15:0] r; logic [2:0] f;} row_s;
   logic       clk_sys;
   logic       rst;
   wire        wr_en;
   wire  [2:0] wr_addr;
   wire  [3:0] wr_data;
   wire  [7:0] src;
   wire  [7:0] lo;
   wire  [7:0] hi;
   wire        busy;
   wire        nf;
   wire        vf;
   wire        zf;
   int         n_errors = 0;
   int         comparisons = 0;
   // overflow rows: sign and zero follow the kept dividend low byte
   row_s rows [10] = '{
      '{1'b0, 8'h64, 16'h5500, 16'h0000, 3'b001}, '{1'b0, 8'h58, 16'hAA64, 16'h2260, 3'b000},
      '{1'b0, 8'h58, 16'h0FC8, 16'h44C0, 3'b000}, '{1'b0, 8'hA5, 16'h00C8, 16'h80E8, 3'b100},
      '{1'b1, 8'h64, 16'h1A16, 16'h4E42, 3'b000}, '{1'b1, 8'h64, 16'h332C, 16'h0083, 3'b100},
      '{1'b1, 8'h58, 16'h0000, 16'h0000, 3'b001}, '{1'b1, 8'h13, 16'h2468, 16'h2468, 3'b010},
      '{1'b1, 8'h00, 16'h1234, 16'h1234, 3'b010}, '{1'b1, 8'h13, 16'h0024, 16'h1101, 3'b000}};
   int_mul_div_unit int_mul_div_unit_i (.clk_sys(clk_sys), .rst(rst), .wr_en(wr_en),
      .wr_addr(wr_addr), .wr_data(wr_data), .source_operand_reg(src), .dest_low_byte(lo),
      .dest_high_byte(hi), .op_select_start(busy), .negative_flag(nf), .overflow_flag(vf),
      .zero_flag(zf));
   host_cpu host_cpu_i (.clk_sys(clk_sys), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   // host must not read results while the unit still runs
   task automatic finish_op(input int n);
      int cnt;
      cnt = 1;
      @(negedge clk_sys);
      chk("busy", 16'h0001, 16'(busy));
      while (busy !== 1'b0 && cnt < 30) begin
         @(negedge clk_sys);
         cnt++;
      end
      chk("latency", 16'(n), 16'(cnt));
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (2000) @(posedge clk_sys);
      n_errors++;
      conclude();
   end
   initial begin
      rst = 1'b1;
      repeat (3) @(negedge clk_sys);
      rst = 1'b0;
      for (int i = 0; i < 10; i++) begin
         host_cpu_i.run(rows[i].m, rows[i].s, rows[i].d[15:8], rows[i].d[7:0]);
         finish_op(11);
         chk("result", rows[i].r, {hi, lo});
         chk("flags", 16'(rows[i].f), 16'({nf, vf, zf}));
         $display("row %0d done", i);
      end
      // second step keeps remainder and divisor, loads only the low byte
      host_cpu_i.ldb(mul_div_pkg::OFS_DST_LO_LO, 8'h68);
      host_cpu_i.wr(mul_div_pkg::OFS_CTRL, 4'h1);
      finish_op(11);
      chk("two step", 16'h0AEA, {hi, lo});
      chk("two step flags", 16'h0004, 16'({nf, vf, zf}));
      $display("two step done");
      host_cpu_i.run(1'b0, 8'hA5, 8'h33, 8'hC8);
      host_cpu_i.ldb(mul_div_pkg::OFS_SRC_LO, 8'h01);
      finish_op(7);
      chk("mid-run write", 16'h80E8, {hi, lo});
      chk("kept operand", 16'h0001, 16'(src));
      $display("mid-run write done");
      host_cpu_i.run(1'b1, 8'h13, 8'h24, 8'h68);
      rst = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk("reset state", 16'h0000, 16'({busy, nf, vf, zf}));
      rst = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk("after release", 16'h0000, 16'({busy, nf, vf, zf}));
      $display("reset done");
      conclude();
   end
endmodule // tb
`default_nettype wire
